// [rtl/gds_pkg.sv]
// Shared constants, register layout, timing and types for the gate drive sequencer.
package gds_pkg;

  // Core clock rate in MHz; every time below is converted with it.
  localparam int CLK_MHZ = 200;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  // Control register field positions.
  localparam int CTRL_CUR_LSB = 0;
  localparam int CTRL_LONG = 4;
  localparam int CTRL_TDRV_LSB = 5;
  localparam int CTRL_DEAD_LSB = 8;
  localparam int CTRL_LSREF = 12;
  localparam int CTRL_INDEP_LSB = 13;
  localparam int CTRL_TRIP_LSB = 16;
  localparam int CTRL_OCSHUT = 20;
  localparam int CTRL_BITS = 21;
  // Control reset: current code 0, long window on, drive time code 3, trip code 4, shutdown on overcurrent.
  localparam logic [31:0] CTRL_RESET = 32'h0014_0070;

  // Status register field positions (all sticky, write one to clear).
  localparam int ST_FAULT = 0;
  localparam int ST_UV = 1;
  localparam int ST_CPUV = 2;
  localparam int ST_GDF_HI_LSB = 3;
  localparam int ST_GDF_LO_LSB = 6;
  localparam int ST_OC_HI_LSB = 9;
  localparam int ST_OC_LO_LSB = 12;
  localparam int ST_BITS = 15;
  localparam logic [ST_BITS-1:0] STATUS_RESET = 15'h0000;

  // Times in nanoseconds and their cycle counts (least times rounded up).
  localparam int PWM_DEGLITCH_NS = 50;
  localparam int PWM_DEGLITCH_CYC = (PWM_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int OCP_DEGLITCH_NS = 4000;
  localparam int OCP_DEGLITCH_CYC = (OCP_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int LONG_DRIVE_NS = 20000;
  localparam int DEAD_STEP_NS = 100;
  localparam int DEAD_STEP_CYC = (DEAD_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int UV_WINDOW_NS = 100000;
  localparam int UV_WINDOW_CYC = UV_WINDOW_NS * CLK_MHZ / 1000;

  // Counter widths.
  localparam int WIN_W = 12;
  localparam int DEAD_W = 9;
  localparam int UV_W = 16;
  localparam logic [WIN_W-1:0] LONG_DRIVE_CYC = WIN_W'((LONG_DRIVE_NS * CLK_MHZ + 999) / 1000);

  // Drive window length in cycles for each drive time code.
  function automatic logic [WIN_W-1:0] gds_gate_drive_time_cyc(input logic [2:0] code);
    int ns;
    unique case (code)
      3'h0: ns = 500;
      3'h1: ns = 1000;
      3'h2: ns = 2000;
      3'h3: ns = 3000;
      3'h4: ns = 4000;
      3'h5: ns = 5000;
      3'h6: ns = 8000;
      3'h7: ns = 10000;
    endcase
    return WIN_W'((ns * CLK_MHZ + 999) / 1000);
  endfunction

  // Per phase sequencing states.
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_DEAD = 2'b01,
    PH_DRIVE = 2'b10
  } gds_phase_e;

endpackage

// [rtl/gds_if.sv]
// Register access carrier between the APB slave and the sequencer core.
`timescale 1ns/1ps
interface gds_if;
  logic wr; // One-cycle write strobe at the completing APB edge.
  logic [7:0] addr; // Byte address of the current transfer.
  logic [31:0] wdata; // Write data of the current transfer.
  logic [31:0] rdata; // Read data for the addressed register.
  logic hit; // High when the address maps to a register.
  modport bus (output wr, output addr, output wdata, input rdata, input hit);
  modport core (input wr, input addr, input wdata, output rdata, output hit);
endinterface

// [rtl/gds_filter.sv]
// Two-flop synchroniser with a per-bit deglitch counter.
`timescale 1ns/1ps
module gds_filter #(
  parameter int W = 1,
  parameter int CNT = 1,
  parameter bit BOTH = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  localparam int CW = $clog2(CNT + 1);
  logic [W-1:0] meta_ff; // First synchroniser stage, read only by the second.
  logic [W-1:0] sync_ff; // Second synchroniser stage.

  if (CNT < 1 || W < 1) begin : g_bad
    $error("gds_filter needs CNT and W of at least one");
  end

  // Bring the raw inputs into the clock domain.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [CW-1:0] cnt_ff; // Cycles the new level has held.
    logic q_ff; // Filtered level.
    // A new level is accepted only after it held CNT cycles, but a fall is taken at once when BOTH is off; a return restarts the count.
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_ff <= '0;
        q_ff <= 1'b0;
      end else if (sync_ff[i] == q_ff) begin
        cnt_ff <= '0;
      end else if (!BOTH && !sync_ff[i]) begin
        q_ff <= 1'b0;
        cnt_ff <= '0;
      end else if (cnt_ff == CW'(CNT - 1)) begin
        q_ff <= sync_ff[i];
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
    assign dout[i] = q_ff;
  end

endmodule // gds_filter

// [rtl/gds_apb.sv]
// APB slave front end with one wait-free access phase.
`timescale 1ns/1ps
module gds_apb (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  gds_if.bus rif
);
  logic [31:0] prdata_ff; // Read data captured at the setup edge.
  logic pready_ff; // High for exactly the first access cycle.
  logic pslverr_ff; // Error answer for unmapped addresses.
  logic setup; // Setup cycle of a transfer.

  assign setup = psel && !penable;
  assign rif.addr = paddr;
  assign rif.wdata = pwdata;
  // A write takes effect only at the edge that completes the access.
  assign rif.wr = psel && penable && pwrite && pready_ff && rif.hit;

  // Answer every transfer in its first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !rif.hit;
      if (setup) begin
        prdata_ff <= (!pwrite && rif.hit) ? rif.rdata : 32'h0000_0000;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

endmodule // gds_apb

// [rtl/gds_top.sv]
// Gate drive sequencer: gate timing, dead time, gate fault and overcurrent monitors, fault pin.
// How it works
// - Charge pump undervoltage blocks gates, sets status.
// - Sixteen current codes; seven in hardware build.
// - Selected current during window, then hold current.
// - Overcurrent drops output current code to lowest.
// - Turn-on waits for opposite gate monitor low.
// - Programmable digital dead time added, serial only.
// - Strong pulldown on opposite gate during window.
// - Gate monitor mismatch at window end flags fault.
// - New PWM command ends window early.
// - Long window default for codes zero to three, serial only.
// - Long enable write ignored for higher codes.
// - Overcurrent after deglitch; optional phase shutdown.
// - Register selects low-side monitor reference input, serial only.
// - Trip threshold code output to analog comparator.
// - Fault pin pulled low while any fault.
// - Supply must be good within window after reset.
// - Supply missing its power-up window latches fault and undervoltage bits.
// - PWM inputs deglitched before use.
// - Independent FET phases bypass dead time.
`timescale 1ns/1ps
module gds_top
  import gds_pkg::*;
#(
  parameter int NUM_PHASES = 3,
  parameter bit HW_CONFIG = 1'b0,
  parameter int UV_CYCLES = UV_WINDOW_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_PHASES-1:0] pwm_high_in,
  input wire logic [NUM_PHASES-1:0] pwm_low_in,
  input wire logic [NUM_PHASES-1:0] vgs_high_ok,
  input wire logic [NUM_PHASES-1:0] vgs_low_ok,
  input wire logic [NUM_PHASES-1:0] vds_high_trip,
  input wire logic [NUM_PHASES-1:0] vds_low_trip_pos,
  input wire logic [NUM_PHASES-1:0] vds_low_trip_neg,
  input wire logic cp_undervoltage,
  input wire logic vm_above_min,
  output logic [NUM_PHASES-1:0] high_gate_x,
  output logic [NUM_PHASES-1:0] low_gate_x,
  output logic [NUM_PHASES-1:0] high_drive_strong,
  output logic [NUM_PHASES-1:0] low_drive_strong,
  output logic [NUM_PHASES-1:0] high_pulldown_strong,
  output logic [NUM_PHASES-1:0] low_pulldown_strong,
  output logic [3:0] gate_current_select,
  output logic [3:0] drain_trip_level,
  output logic low_side_ref_select,
  output logic fault_out_n_o,
  output logic fault_out_n_oe
);

  if (NUM_PHASES != 3) begin : g_bad_phases
    $error("gds_top register layout serves exactly three phases");
  end
  if (UV_CYCLES < 1 || UV_CYCLES >= (1 << UV_W)) begin : g_bad_uv
    $error("gds_top UV_CYCLES must fit the power-up counter");
  end

  gds_if rif ();

  logic [CTRL_BITS-1:0] ctrl_ff; // Control register.
  logic [ST_BITS-1:0] status_ff; // Sticky status register.
  logic [NUM_PHASES-1:0] pwm_h; // Deglitched high-side commands.
  logic [NUM_PHASES-1:0] pwm_l; // Deglitched low-side commands.
  logic [2*NUM_PHASES+1:0] mon; // Synchronised gate monitors and supply flags.
  logic [3*NUM_PHASES-1:0] oc_raw; // Deglitched overcurrent comparators.
  logic [NUM_PHASES-1:0] vgs_h; // High gate above threshold.
  logic [NUM_PHASES-1:0] vgs_l; // Low gate above threshold.
  logic cp_uv; // Charge pump undervoltage, synchronised.
  logic vm_ok; // Motor supply above minimum, synchronised.
  logic [NUM_PHASES-1:0] oc_h; // High-side overcurrent detected.
  logic [NUM_PHASES-1:0] oc_l; // Low-side overcurrent on the selected reference.
  logic [NUM_PHASES-1:0] gdf_h_ff; // High gate fault pulse.
  logic [NUM_PHASES-1:0] gdf_l_ff; // Low gate fault pulse.
  logic [UV_W-1:0] uv_cnt_ff; // Power-up supply wait counter.
  logic pu_done_ff; // Power-up check finished.
  logic uv_evt_ff; // One-cycle pulse when the supply missed its window.
  logic lockout; // Supply condition that forbids driving gates.
  logic [3:0] cur_code; // Current code as the hardware applies it.
  logic long_eff; // Long window actually in use.
  logic [WIN_W-1:0] win_cyc; // Drive window length in cycles.
  logic [DEAD_W-1:0] dead_cyc; // Digital dead time in cycles.
  logic [ST_BITS-1:0] st_set; // Status events this cycle.
  logic [3:0] cur_out_ff; // Applied current code.
  logic fault_oe_ff; // Fault pin pull-down enable.
  logic fault_o_ff; // Fault pin data, always low.

  gds_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rif(rif.bus)
  );

  // PWM pins are deglitched on both edges.
  gds_filter #(.W(2 * NUM_PHASES), .CNT(PWM_DEGLITCH_CYC), .BOTH(1'b1)) u_pwm_filt (
    .clk(pclk),
    .rst_n(presetn),
    .din({pwm_low_in, pwm_high_in}),
    .dout({pwm_l, pwm_h})
  );

  // Gate monitors and supply flags only need synchronising.
  gds_filter #(.W(2 * NUM_PHASES + 2), .CNT(1), .BOTH(1'b1)) u_mon_filt (
    .clk(pclk),
    .rst_n(presetn),
    .din({vm_above_min, cp_undervoltage, vgs_low_ok, vgs_high_ok}),
    .dout(mon)
  );

  // Overcurrent rises only after the deglitch time and falls at once.
  gds_filter #(.W(3 * NUM_PHASES), .CNT(OCP_DEGLITCH_CYC), .BOTH(1'b0)) u_oc_filt (
    .clk(pclk),
    .rst_n(presetn),
    .din({vds_low_trip_neg, vds_low_trip_pos, vds_high_trip}),
    .dout(oc_raw)
  );

  assign vgs_h = mon[NUM_PHASES-1:0];
  assign vgs_l = mon[2*NUM_PHASES-1:NUM_PHASES];
  assign cp_uv = mon[2*NUM_PHASES];
  assign vm_ok = mon[2*NUM_PHASES+1];
  assign oc_h = oc_raw[NUM_PHASES-1:0];
  // The low-side monitor compares against the positive or negative sense input.
  assign oc_l = (ctrl_ff[CTRL_LSREF] && !HW_CONFIG) ? oc_raw[3*NUM_PHASES-1:2*NUM_PHASES] :
                oc_raw[2*NUM_PHASES-1:NUM_PHASES];

  // Gates stay off until the supply check finishes and while either supply is low.
  assign lockout = !pu_done_ff || !vm_ok || cp_uv;

  // Hardware builds only have seven current levels.
  assign cur_code = (HW_CONFIG && ctrl_ff[CTRL_CUR_LSB+:4] > 4'h6) ? 4'h6 : ctrl_ff[CTRL_CUR_LSB+:4];
  assign long_eff = ctrl_ff[CTRL_LONG] && (cur_code <= 4'h3) && !HW_CONFIG;
  assign win_cyc = long_eff ? LONG_DRIVE_CYC : gds_gate_drive_time_cyc(ctrl_ff[CTRL_TDRV_LSB+:3]);
  assign dead_cyc = HW_CONFIG ? '0 : DEAD_W'(ctrl_ff[CTRL_DEAD_LSB+:4] * DEAD_STEP_CYC);

  // Register read mux and address decode.
  assign rif.hit = (rif.addr == REG_CTRL) || (rif.addr == REG_STATUS);
  always_comb begin
    rif.rdata = 32'h0000_0000;
    if (rif.addr == REG_CTRL) begin
      rif.rdata[CTRL_BITS-1:0] = ctrl_ff;
    end else if (rif.addr == REG_STATUS) begin
      rif.rdata[ST_BITS-1:0] = status_ff;
    end
  end

  // Control register; the long enable bit only accepts writes with a low current code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET[CTRL_BITS-1:0];
    end else if (rif.wr && rif.addr == REG_CTRL) begin
      ctrl_ff <= rif.wdata[CTRL_BITS-1:0];
      if (rif.wdata[CTRL_CUR_LSB+:4] > 4'h3) begin
        ctrl_ff[CTRL_LONG] <= ctrl_ff[CTRL_LONG];
      end
    end
  end

  // Power-up supply check: the check finishes as soon as the supply is seen good.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_cnt_ff <= '0;
      pu_done_ff <= 1'b0;
      uv_evt_ff <= 1'b0;
    end else begin
      uv_evt_ff <= 1'b0;
      if (!pu_done_ff) begin
        if (vm_ok) begin
          pu_done_ff <= 1'b1;
          uv_cnt_ff <= '0;
        end else if (uv_cnt_ff == UV_W'(UV_CYCLES - 1)) begin
          uv_evt_ff <= 1'b1;
          pu_done_ff <= 1'b1;
        end else begin
          uv_cnt_ff <= uv_cnt_ff + UV_W'(1);
        end
      end
    end
  end

  // Collect this cycle's fault events.
  always_comb begin
    st_set = '0;
    st_set[ST_UV] = uv_evt_ff;
    st_set[ST_CPUV] = cp_uv;
    st_set[ST_GDF_HI_LSB+:3] = gdf_h_ff;
    st_set[ST_GDF_LO_LSB+:3] = gdf_l_ff;
    st_set[ST_OC_HI_LSB+:3] = oc_h;
    st_set[ST_OC_LO_LSB+:3] = oc_l;
    st_set[ST_FAULT] = |st_set[ST_BITS-1:1];
  end

  // Sticky status with write-one-to-clear; a new event wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= STATUS_RESET;
    end else if (rif.wr && rif.addr == REG_STATUS) begin
      status_ff <= (status_ff & ~rif.wdata[ST_BITS-1:0]) | st_set;
    end else begin
      status_ff <= status_ff | st_set;
    end
  end

  // Applied current code falls to the lowest level during an overcurrent.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_out_ff <= 4'h0;
    end else if ((|oc_h) || (|oc_l)) begin
      cur_out_ff <= 4'h0;
    end else begin
      cur_out_ff <= cur_code;
    end
  end

  // Fault pin is pulled low while any status bit stands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_oe_ff <= 1'b0;
      fault_o_ff <= 1'b0;
    end else begin
      fault_oe_ff <= |status_ff;
      fault_o_ff <= 1'b0;
    end
  end

  for (genvar i = 0; i < NUM_PHASES; i++) begin : g_phase
    gds_phase_e st_ff; // Sequencing state.
    logic gh_ff; // High gate on.
    logic gl_ff; // Low gate on.
    logic win_h_ff; // High gate switching inside the window.
    logic win_l_ff; // Low gate switching inside the window.
    logic [WIN_W-1:0] win_cnt_ff; // Remaining window cycles.
    logic [DEAD_W-1:0] dead_cnt_ff; // Dead time cycles elapsed.
    logic [1:0] cmd_prev_ff; // Command seen last cycle.
    logic indep; // Phase runs as two independent FETs.
    logic block; // Phase forced off.
    logic want_h; // High gate should be on.
    logic want_l; // Low gate should be on.
    logic off_h; // High gate must turn off.
    logic off_l; // Low gate must turn off.
    logic on_h; // High gate waits to turn on.
    logic on_l; // Low gate waits to turn on.
    logic cmd_chg; // PWM command changed this cycle.
    logic settled; // Opposite gate is off and its monitor shows it low.

    assign indep = ctrl_ff[CTRL_INDEP_LSB+i];
    assign block = lockout || (ctrl_ff[CTRL_OCSHUT] &&
                   (status_ff[ST_OC_HI_LSB+i] || status_ff[ST_OC_LO_LSB+i]));
    // Half-bridges never turn both gates on; both commanded means both off.
    assign want_h = !block && pwm_h[i] && (indep || !pwm_l[i]);
    assign want_l = !block && pwm_l[i] && (indep || !pwm_h[i]);
    assign off_h = gh_ff && !want_h;
    assign off_l = gl_ff && !want_l;
    assign on_h = !gh_ff && want_h;
    assign on_l = !gl_ff && want_l;
    assign cmd_chg = {pwm_h[i], pwm_l[i]} != cmd_prev_ff;
    assign settled = on_h ? (!gl_ff && !vgs_l[i]) : (!gh_ff && !vgs_h[i]);

    // Drive state machine: off first, handshake dead time, then the drive window.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_ff <= PH_IDLE;
        gh_ff <= 1'b0;
        gl_ff <= 1'b0;
        win_h_ff <= 1'b0;
        win_l_ff <= 1'b0;
        win_cnt_ff <= '0;
        dead_cnt_ff <= '0;
        cmd_prev_ff <= 2'b00;
        gdf_h_ff[i] <= 1'b0;
        gdf_l_ff[i] <= 1'b0;
      end else begin
        cmd_prev_ff <= {pwm_h[i], pwm_l[i]};
        gdf_h_ff[i] <= 1'b0;
        gdf_l_ff[i] <= 1'b0;
        unique case (st_ff)
          PH_IDLE: begin
            if (off_h || off_l || (indep && (on_h || on_l))) begin
              // Switch now and open the window for the gates that move.
              gh_ff <= indep ? want_h : (gh_ff && !off_h);
              gl_ff <= indep ? want_l : (gl_ff && !off_l);
              win_h_ff <= off_h || (indep && on_h);
              win_l_ff <= off_l || (indep && on_l);
              win_cnt_ff <= win_cyc;
              st_ff <= PH_DRIVE;
            end else if (on_h || on_l) begin
              dead_cnt_ff <= '0;
              st_ff <= PH_DEAD;
            end
          end
          PH_DEAD: begin
            if (cmd_chg || !(on_h || on_l)) begin
              st_ff <= PH_IDLE;
            end else if (!settled) begin
              dead_cnt_ff <= '0;
            end else if (dead_cnt_ff >= dead_cyc) begin
              gh_ff <= on_h;
              gl_ff <= on_l;
              win_h_ff <= on_h;
              win_l_ff <= on_l;
              win_cnt_ff <= win_cyc;
              st_ff <= PH_DRIVE;
            end else begin
              dead_cnt_ff <= dead_cnt_ff + DEAD_W'(1);
            end
          end
          PH_DRIVE: begin
            if (cmd_chg || off_h || off_l) begin
              // A new command cuts the window short.
              win_h_ff <= 1'b0;
              win_l_ff <= 1'b0;
              st_ff <= PH_IDLE;
            end else if (!indep && (on_h || on_l) && settled) begin
              // The turned-off gate is already low, so start the dead time.
              win_h_ff <= 1'b0;
              win_l_ff <= 1'b0;
              dead_cnt_ff <= '0;
              st_ff <= PH_DEAD;
            end else if (win_cnt_ff == '0) begin
              // Gate voltage must match the commanded state when the window closes.
              gdf_h_ff[i] <= win_h_ff && (vgs_h[i] != gh_ff);
              gdf_l_ff[i] <= win_l_ff && (vgs_l[i] != gl_ff);
              win_h_ff <= 1'b0;
              win_l_ff <= 1'b0;
              st_ff <= PH_IDLE;
            end else begin
              win_cnt_ff <= win_cnt_ff - WIN_W'(1);
            end
          end
          default: begin
            st_ff <= PH_IDLE;
          end
        endcase
      end
    end

    assign high_gate_x[i] = gh_ff;
    assign low_gate_x[i] = gl_ff;
    assign high_drive_strong[i] = win_h_ff;
    assign low_drive_strong[i] = win_l_ff;
    assign low_pulldown_strong[i] = win_h_ff;
    assign high_pulldown_strong[i] = win_l_ff;
  end

  assign gate_current_select = cur_out_ff;
  assign drain_trip_level = ctrl_ff[CTRL_TRIP_LSB+:4];
  assign low_side_ref_select = ctrl_ff[CTRL_LSREF];
  assign fault_out_n_o = fault_o_ff;
  assign fault_out_n_oe = fault_oe_ff;

endmodule // gds_top

// [bench/gds_top_asserts.sv]
// Port-level assertions for the gate drive sequencer.
`timescale 1ns/1ps
module gds_top_asserts #(
  parameter int NUM_PHASES = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cp_undervoltage,
  input wire logic vm_above_min,
  input wire logic [NUM_PHASES-1:0] high_gate_x,
  input wire logic [NUM_PHASES-1:0] low_gate_x,
  input wire logic [NUM_PHASES-1:0] high_drive_strong,
  input wire logic [NUM_PHASES-1:0] low_drive_strong,
  input wire logic [NUM_PHASES-1:0] high_pulldown_strong,
  input wire logic [NUM_PHASES-1:0] low_pulldown_strong,
  input wire logic [3:0] drain_trip_level,
  input wire logic low_side_ref_select,
  input wire logic fault_out_n_o,
  input wire logic fault_out_n_oe
);
  // Every check runs on the bus clock and rests during reset.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready is not a single pulse");
  a_unmapped_error: assert property (pready && paddr != 8'h00 && paddr != 8'h04 |-> pslverr)
    else $error("no error for unmapped address");
  a_pin_low_only: assert property (!fault_out_n_o)
    else $error("fault pin driven high");
  a_pump_fault_pin: assert property (cp_undervoltage [*8] |-> fault_out_n_oe)
    else $error("fault pin not pulled with pump low");
  a_pull_opposite: assert property (low_pulldown_strong == high_drive_strong && high_pulldown_strong == low_drive_strong)
    else $error("opposite pulldown mismatch");
  a_off_strong: assert property ($fell(high_gate_x[0]) |-> high_drive_strong[0])
    else $error("turn-off without selected current");
  a_supply_blocks: assert property (!vm_above_min [*6] |-> high_gate_x == '0 && low_gate_x == '0)
    else $error("gate on with low supply");
  a_pump_blocks: assert property (cp_undervoltage [*6] |-> high_gate_x == '0 && low_gate_x == '0)
    else $error("gate on with pump low");
  a_ctrl_fields: assert property (psel && penable && pready && pwrite && paddr == 8'h00 |=>
    drain_trip_level == $past(pwdata[19:16]) && low_side_ref_select == $past(pwdata[12]))
    else $error("trip or reference field wrong");
endmodule // gds_top_asserts

// [bench/gds_fet_model.sv]
// External MOSFET gate threshold monitors.
`timescale 1ns/1ps
module gds_fet_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] high_gate_x,
  input wire logic [2:0] low_gate_x,
  input wire logic [2:0] stuck_low,
  output logic [2:0] vgs_high_ok,
  output logic [2:0] vgs_low_ok
);
  logic [5:0] gate_d; // Gates one cycle late, standing for charge time.
  // Monitors follow their gates two cycles later; a stuck high gate never charges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {gate_d, vgs_high_ok, vgs_low_ok} <= '0;
    end else begin
      gate_d <= {high_gate_x, low_gate_x};
      vgs_high_ok <= gate_d[5:3] & ~stuck_low;
      vgs_low_ok <= gate_d[2:0];
    end
  end
endmodule // gds_fet_model

// [bench/tb_top.sv]
// Self-checking bench for the gate drive sequencer.
`timescale 1ns/1ps
module tb_top;
  import gds_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, d;
  logic pready, pslverr, cp_undervoltage = 0, vm_above_min = 1, fault_out_n_o, fault_out_n_oe;
  logic [2:0] pwm_high_in = 0, pwm_low_in = 0, vds_high_trip = 0, vds_low_trip_pos = 0, vds_low_trip_neg = 0;
  logic [2:0] stuck = 0, vgs_high_ok, vgs_low_ok, high_gate_x, low_gate_x;
  logic [2:0] high_drive_strong, low_drive_strong, high_pulldown_strong, low_pulldown_strong;
  logic [3:0] gate_current_select, drain_trip_level;
  logic low_side_ref_select;
  int n_mismatch = 0, check_count = 0, n;
  // Short supply window keeps the power-up check brief.
  gds_top #(.UV_CYCLES(50)) i_dut (.*);
  gds_fet_model i_fet (.pclk(pclk), .presetn(presetn), .high_gate_x(high_gate_x), .low_gate_x(low_gate_x),
    .stuck_low(stuck), .vgs_high_ok(vgs_high_ok), .vgs_low_ok(vgs_low_ok));
  initial forever #2.5 pclk = ~pclk;
  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %0t: got %h want %h", $time, g, x);
    end
  endtask
  // One APB transfer; the request holds until ready is sampled.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, '0);
    chk(r, x);
  endtask
  // Expected control read-back: the long window bit moves only with a low code.
  function automatic logic [31:0] cexp(input logic [31:0] v, input logic l);
    cexp = v & 32'h001F_FFFF;
    if (v[3:0] > 4'h3) cexp[4] = l;
  endfunction
  task automatic end_sim;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(70));
    wt(12);
    presetn <= 1'b1;
    wt(1);
    rd(REG_CTRL, CTRL_RESET);
    rd(8'h08, '0);
    chk(e, 1'b1);
    apb(1'b1, REG_CTRL, 32'h0014_0062);
    rd(REG_CTRL, cexp(32'h0014_0062, 1'b1));
    chk(gate_current_select, 4'h2);
    apb(1'b1, REG_CTRL, 32'h0014_0075);
    rd(REG_CTRL, cexp(32'h0014_0075, 1'b0));
    repeat (4) begin
      d = ($urandom & 32'h001F_FFF0) | (32'd4 + $urandom % 12);
      apb(1'b1, REG_CTRL, d);
      rd(REG_CTRL, cexp(d, 1'b0));
      chk(gate_current_select, d[3:0]);
    end
    apb(1'b1, REG_CTRL, 32'h0014_0104);
    pwm_high_in <= 3'b001;
    wt(4);
    pwm_high_in <= 3'b000;
    wt(30);
    chk(high_gate_x, 3'b000);
    pwm_high_in <= 3'b001;
    wt(45);
    chk({high_gate_x[0], high_drive_strong[0], low_pulldown_strong[0]}, 3'b111);
    wt(120);
    chk(high_drive_strong[0], 1'b0);
    rd(REG_STATUS, '0);
    pwm_high_in <= 3'b000;
    pwm_low_in <= 3'b001;
    n = 0;
    while (low_gate_x[0] !== 1'b1 && n < 100) begin
      n++;
      @(posedge pclk);
    end
    chk(n >= 36 && n < 100, 1'b1);
    wt(150);
    pwm_low_in <= 3'b000;
    stuck <= 3'b010;
    pwm_high_in <= 3'b010;
    wt(200);
    rd(REG_STATUS, 32'h1 | (32'h1 << (ST_GDF_HI_LSB + 1)));
    chk(fault_out_n_oe, 1'b1);
    pwm_high_in <= 3'b000;
    stuck <= 3'b000;
    wt(150);
    apb(1'b1, REG_STATUS, 32'h0000_7FFF);
    wt(3);
    chk(fault_out_n_oe, 1'b0);
    apb(1'b1, REG_CTRL, 32'h0014_5104);
    pwm_high_in <= 3'b010;
    pwm_low_in <= 3'b010;
    wt(40);
    chk({high_gate_x[1], low_gate_x[1]}, 2'b11);
    pwm_high_in <= 3'b000;
    pwm_low_in <= 3'b000;
    wt(20);
    chk({high_gate_x[1], low_gate_x[1]}, 2'b00);
    wt(130);
    vds_high_trip <= 3'b100;
    wt(700);
    vds_high_trip <= 3'b000;
    wt(2);
    rd(REG_STATUS, '0);
    vds_high_trip <= 3'b100;
    vds_low_trip_pos <= 3'b001;
    vds_low_trip_neg <= 3'b010;
    wt(900);
    chk(gate_current_select, 4'h0);
    {vds_high_trip, vds_low_trip_pos, vds_low_trip_neg} <= '0;
    rd(REG_STATUS, 32'h1 | (32'h1 << (ST_OC_HI_LSB + 2)) | (32'h1 << (ST_OC_LO_LSB + 1)));
    vm_above_min <= 1'b0;
    cp_undervoltage <= 1'b1;
    presetn <= 1'b0;
    wt(3);
    presetn <= 1'b1;
    wt(80);
    rd(REG_STATUS, 32'h7);
    end_sim;
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end
endmodule // tb_top
bind gds_top gds_top_asserts #(.NUM_PHASES(NUM_PHASES)) i_chk (.*);
